//--- hdl/mss_pkg.sv
// Package with timing constants and state types of the mains sense supply supervisor.
package mss_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    // Times as printed, in their own units.
    localparam int unsigned WIN_US = 20;
    localparam int unsigned PRE_BI_US = 1000;
    localparam int unsigned NORM_INT_US = 6700;
    localparam int unsigned BURST_INT_US = 101_000;
    localparam int unsigned GROUP_WAIT_US = 6700;
    localparam int unsigned BROWNOUT_US = 30_000;
    // Derived cycle counts: least times, clock rate truncated to whole MHz.
    localparam int unsigned WIN_CYC = (WIN_US * (CLK_HZ / 1_000_000));
    localparam int unsigned PRE_BI_CYC = (PRE_BI_US * (CLK_HZ / 1_000_000));
    localparam int unsigned NORM_INT_CYC = (NORM_INT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned BURST_INT_CYC = (BURST_INT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned GROUP_WAIT_CYC = (GROUP_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned BROWNOUT_CYC = (BROWNOUT_US * (CLK_HZ / 1_000_000));
    // Sample pulses per group before the group wait.
    localparam int unsigned GROUP_PULSES = 3;
    // Counter width able to hold the longest interval.
    localparam int unsigned CNT_W = 22;
    // Start-up sequence states.
    typedef enum logic [1:0] {
        MSS_ST_OFF,
        MSS_ST_HOLD,
        MSS_ST_RUN
    } mss_state_e;
endpackage : mss_pkg

//--- hdl/mss_sync2.sv
// Two flip-flop synchroniser for a vector of asynchronous comparator levels.
`timescale 1ns/10ps
`default_nettype none
module mss_sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;
endmodule // mss_sync2
`default_nettype wire

//--- hdl/mss_supervisor.sv
// Supervisor sequencing mains sensing, brownin, brownout, supply strokes and gate enable.
// What this block does
// R1 - Each mains-sense sampling window lasts 20 microseconds.
// R2 - Before brownin, a new sampling window starts every 1 millisecond.
// R3 - After brownin, interval is 6.7 ms normally, 101 ms in burst.
// R4 - Window grounds the sense pin; current is captured at window end.
// R5 - Before brownin at start level, sensing runs as three pulses then 6.7 ms wait.
// R6 - One sample above 663 uA satisfies brownin; sensing continues afterwards.
// R7 - Without brownin at start level, source regulates low supply rail at 14.9 V.
// R8 - Brownout stops switching after 30 ms continuously below 587 uA.
// R9 - With switching stopped and rail at 11 V, insert minimum-current strokes.
// R10 - Stop strokes above restart plus 100 mV; repeat at next restart level.
// R11 - Leave stroke mode for burst switching when control current falls to 100 uA.
// R12 - Flag demagnetization when aux input falls below 40 mV after switch-off.
// R13 - Gate drive may switch on only after demagnetization is flagged.
// R14 - While switch is on, clamp aux input and measure compensation current.
// R15 - After start level, switching waits for brownin and protect above 0.55 V.
// R16 - All comparator results are synchronised before use.
// R17 - Reset clears brownin, disables switching, restarts scheduler pre-brownin.
`timescale 1ns/10ps
`default_nettype none
module mss_supervisor #(
    parameter int unsigned WIN_CYC = mss_pkg::WIN_CYC,
    parameter int unsigned PRE_BI_CYC = mss_pkg::PRE_BI_CYC,
    parameter int unsigned NORM_INT_CYC = mss_pkg::NORM_INT_CYC,
    parameter int unsigned BURST_INT_CYC = mss_pkg::BURST_INT_CYC,
    parameter int unsigned GROUP_WAIT_CYC = mss_pkg::GROUP_WAIT_CYC,
    parameter int unsigned BROWNOUT_CYC = mss_pkg::BROWNOUT_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Asynchronous comparator results from the analog front ends.
    input wire logic start_level_i,
    input wire logic restart_level_i,
    input wire logic restart_hyst_i,
    input wire logic sense_above_bi_i,
    input wire logic sense_above_bo_i,
    input wire logic protect_ok_i,
    input wire logic ctrl_low_i,
    input wire logic ctrl_high_i,
    input wire logic aux_demag_i,
    // Same-domain inputs from the switching core.
    input wire logic burst_mode_i,
    input wire logic gate_request_i,
    // Mains sense pin control.
    output logic sense_ground_o,
    output logic sense_capture_o,
    output logic hv_regulate_o,
    // Status and switching control.
    output logic brownin_o,
    output logic brownout_o,
    output logic switch_enable_o,
    output logic stroke_min_o,
    output logic demag_o,
    output logic gate_on_o,
    output logic aux_clamp_o,
    output logic aux_measure_o
);
    localparam int unsigned CW = mss_pkg::CNT_W;
    localparam logic [CW-1:0] WIN_C = CW'(WIN_CYC - 1);
    localparam logic [CW-1:0] PRE_C = CW'(PRE_BI_CYC - WIN_CYC - 1);
    localparam logic [CW-1:0] NORM_C = CW'(NORM_INT_CYC - WIN_CYC - 1);
    localparam logic [CW-1:0] BURST_C = CW'(BURST_INT_CYC - WIN_CYC - 1);
    localparam logic [CW-1:0] GWAIT_C = CW'(GROUP_WAIT_CYC - 1);
    localparam logic [CW-1:0] BO_C = CW'(BROWNOUT_CYC - 1);
    localparam logic [1:0] PULSES_C = 2'(mss_pkg::GROUP_PULSES);

    // Synchronised comparator levels.
    logic [8:0] cmp_s;
    logic start_s, restart_s, hyst_s, bi_s, bo_s, prot_s, ctrl_lo_s, ctrl_hi_s, demag_s;

    mss_sync2 #(.W(9)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i({start_level_i, restart_level_i, restart_hyst_i, sense_above_bi_i,
                  sense_above_bo_i, protect_ok_i, ctrl_low_i, ctrl_high_i, aux_demag_i}),
        .sync_o(cmp_s)
    ); // [R16]
    assign {start_s, restart_s, hyst_s, bi_s, bo_s, prot_s, ctrl_lo_s, ctrl_hi_s, demag_s} = cmp_s;

    // Sampling scheduler state.
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic win_r, win_nxt;
    logic cap_r, cap_nxt;
    logic [1:0] pulse_r, pulse_nxt;

    // Sequencer and supervision state.
    mss_pkg::mss_state_e st_r, st_nxt;
    logic bi_r, bi_nxt;
    logic bo_flag_r, bo_flag_nxt;
    logic [CW-1:0] bo_cnt_r, bo_cnt_nxt;
    logic stroke_r, stroke_nxt;
    logic demag_r, demag_nxt;
    logic gate_r, gate_nxt;
    // Gate history, one bit per synchroniser stage on the aux level.
    logic [1:0] gate_hist_r, gate_hist_nxt;
    logic hvreg_r, hvreg_nxt;

    // Window and interval timing; window ends capture the measured current.
    always_comb begin
        cnt_nxt = cnt_r;
        win_nxt = win_r;
        cap_nxt = 1'b0;
        pulse_nxt = pulse_r;
        if (!start_s) begin
            cnt_nxt = '0;
            win_nxt = 1'b0;
            pulse_nxt = '0;
        end else if (win_r) begin
            if (cnt_r == WIN_C) begin // [R1]
                win_nxt = 1'b0;
                cap_nxt = 1'b1; // [R4]
                cnt_nxt = '0;
                pulse_nxt = pulse_r + 2'd1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end else if (!bi_r && pulse_r == PULSES_C) begin
            // Group of three done: long wait before the next group.
            if (cnt_r >= GWAIT_C) begin // [R5]
                cnt_nxt = '0;
                pulse_nxt = '0;
                win_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end else begin
            // Inter-window gap: windows start 1 ms apart pre-brownin, else mode-dependent.
            // Ends use >= so that a mode change in mid-gap cannot let the counter wrap.
            if ((!bi_r && cnt_r >= PRE_C) || // [R2]
                (bi_r && !burst_mode_i && cnt_r >= NORM_C) || // [R3]
                (bi_r && burst_mode_i && cnt_r >= BURST_C)) begin
                cnt_nxt = '0;
                win_nxt = 1'b1;
                if (bi_r) begin
                    pulse_nxt = '0;
                end
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin // [R17]
            cnt_r <= '0;
            win_r <= 1'b0;
            cap_r <= 1'b0;
            pulse_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            win_r <= win_nxt;
            cap_r <= cap_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // Brownin, brownout debounce, start-up hold, supply strokes and gate drive.
    always_comb begin
        st_nxt = st_r;
        bi_nxt = bi_r;
        bo_flag_nxt = bo_flag_r;
        bo_cnt_nxt = bo_cnt_r;
        stroke_nxt = stroke_r;
        demag_nxt = demag_r;
        gate_nxt = 1'b0;
        gate_hist_nxt = {gate_hist_r[0], gate_r};
        hvreg_nxt = 1'b0;
        // One captured sample above threshold is enough; sensing keeps running.
        if (cap_r && bi_s) begin // [R6]
            bi_nxt = 1'b1;
        end
        // Brownout needs an unbroken run of low cycles on the synchronised level; a single high cycle clears the count.
        if (cap_r) begin
            if (bo_s) begin
                bo_cnt_nxt = '0;
            end
        end
        if (bi_r && !bo_s && bo_cnt_r != BO_C) begin
            bo_cnt_nxt = bo_cnt_r + 1'b1;
        end else if (bo_s) begin
            bo_cnt_nxt = '0;
        end
        if (bi_r && !bo_s && bo_cnt_r == BO_C) begin // [R8]
            bo_flag_nxt = 1'b1;
            bi_nxt = 1'b0;
        end else if (cap_r && bi_s) begin
            bo_flag_nxt = 1'b0;
        end
        case (st_r)
            mss_pkg::MSS_ST_OFF: begin
                if (start_s) begin
                    st_nxt = mss_pkg::MSS_ST_HOLD;
                end
            end
            mss_pkg::MSS_ST_HOLD: begin
                hvreg_nxt = !bi_r; // [R7]
                if (bi_r && prot_s) begin // [R15]
                    st_nxt = mss_pkg::MSS_ST_RUN;
                end
            end
            mss_pkg::MSS_ST_RUN: begin
                if (bo_flag_nxt || !prot_s) begin // [R8]
                    st_nxt = mss_pkg::MSS_ST_HOLD;
                end
            end
            default: begin
                st_nxt = mss_pkg::MSS_ST_OFF;
            end
        endcase
        // Supply keep-alive strokes while the loop has stopped switching.
        if (st_r != mss_pkg::MSS_ST_RUN) begin
            stroke_nxt = 1'b0;
        end else if (ctrl_lo_s) begin // [R11]
            stroke_nxt = 1'b0;
        end else if (ctrl_hi_s && restart_s) begin // [R9]
            stroke_nxt = 1'b1;
        end else if (hyst_s) begin // [R10]
            stroke_nxt = 1'b0;
        end
        // Demag is blanked while the synchronised aux level may still show the on-time,
        // so a stale low level cannot re-arm the gate right after switch-off.
        if (gate_r || gate_hist_r != '0) begin
            demag_nxt = 1'b0;
        end else if (demag_s) begin // [R12]
            demag_nxt = 1'b1;
        end
        if (st_r == mss_pkg::MSS_ST_RUN && demag_r && !gate_r &&
            (gate_request_i || stroke_r)) begin // [R13]
            gate_nxt = 1'b1;
            demag_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin // [R17]
            st_r <= mss_pkg::MSS_ST_OFF;
            bi_r <= 1'b0;
            bo_flag_r <= 1'b0;
            bo_cnt_r <= '0;
            stroke_r <= 1'b0;
            demag_r <= 1'b0;
            gate_r <= 1'b0;
            gate_hist_r <= '0;
            hvreg_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bi_r <= bi_nxt;
            bo_flag_r <= bo_flag_nxt;
            bo_cnt_r <= bo_cnt_nxt;
            stroke_r <= stroke_nxt;
            demag_r <= demag_nxt;
            gate_r <= gate_nxt;
            gate_hist_r <= gate_hist_nxt;
            hvreg_r <= hvreg_nxt;
        end
    end

    // Outputs come straight from flip-flops, except switch_enable_o, decoded from st_r.
    assign sense_ground_o = win_r; // [R4]
    assign sense_capture_o = cap_r;
    assign hv_regulate_o = hvreg_r;
    assign brownin_o = bi_r;
    assign brownout_o = bo_flag_r;
    assign switch_enable_o = (st_r == mss_pkg::MSS_ST_RUN);
    assign stroke_min_o = stroke_r;
    assign demag_o = demag_r;
    assign gate_on_o = gate_r;
    assign aux_clamp_o = gate_r; // [R14]
    assign aux_measure_o = gate_r; // [R14]

    // Each sampling window stays open for at least 8 cycles.
    a_window_length: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R1]
        $rose(win_r) |-> win_r [*8]) else $error("Sampling window ended early.");
    // Capture follows the last counted window cycle, so a window is never stretched.
    a_capture_at_end: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R4]
        cap_r |-> $past(win_r) && !win_r && $past(cnt_r) == WIN_C)
        else $error("Capture not at window end.");
    // Gate turns on only with demag flagged the cycle before.
    a_gate_after_demag: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R13]
        $rose(gate_r) |-> $past(demag_r)) else $error("Gate on without demag.");
    // No demag flag while the synchronised aux level may still reflect the on-time.
    a_demag_blanking: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R12]
        gate_r |=> (!demag_r) [*3]) else $error("Demag flagged during blanking.");
    // Switching needs brownin.
    a_run_needs_bi: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R15]
        $rose(switch_enable_o) |-> $past(bi_r) && $past(prot_s)) else $error("Run without brownin.");
    // Brownin only from a captured high sample.
    a_brownin_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6]
        $rose(bi_r) |-> $past(cap_r) && $past(bi_s)) else $error("Brownin without sample.");
    // Brownout only after a full count of low cycles.
    a_brownout_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R8]
        $rose(bo_flag_r) |-> $past(bo_cnt_r) == BO_C) else $error("Brownout too early.");
    // Strokes start only at restart level.
    a_stroke_start: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R9]
        $rose(stroke_r) |-> $past(restart_s) && $past(ctrl_hi_s)) else $error("Stroke start bad.");
    // Low control current ends stroke mode next cycle.
    a_stroke_exit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R11]
        ctrl_lo_s |=> !stroke_r) else $error("Stroke mode not left.");
    // Regulation only while holding without brownin.
    a_hv_regulate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
        hvreg_r |-> $past(st_r) == mss_pkg::MSS_ST_HOLD && !$past(bi_r)) else $error("Bad regulate.");
endmodule // mss_supervisor
`default_nettype wire

//--- test/mss_mains_model.sv
// Behavioural model of the mains sense network, auxiliary winding and flyback stage.
`timescale 1ns/10ps
`default_nettype none
module mss_mains_model #(
    parameter int unsigned DEMAG_CYC = 6
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Scenario controls from the bench.
    input wire logic [9:0] mains_ua_i,
    input wire logic ringing_i,
    // Device side.
    input wire logic gate_on_i,
    output logic sense_above_bi_o,
    output logic sense_above_bo_o,
    output logic aux_demag_o
);
    logic [7:0] stroke_cnt_r;
    logic [7:0] stroke_cnt_nxt;

    // The comparators follow the mains level continuously, with no hold between windows.
    // This way a steady mains level never looks like a dip.
    assign sense_above_bi_o = (mains_ua_i > 10'd663);
    assign sense_above_bo_o = (mains_ua_i >= 10'd587);

    // The secondary stroke keeps the aux input high for a while after each switch-off.
    always_comb begin
        stroke_cnt_nxt = (stroke_cnt_r != 8'h00) ? stroke_cnt_r - 8'h01 : 8'h00;
        if (gate_on_i) begin
            stroke_cnt_nxt = 8'(DEMAG_CYC);
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stroke_cnt_r <= 8'h00;
        end else begin
            stroke_cnt_r <= stroke_cnt_nxt;
        end
    end
    // Without ringing the winding never demagnetises, which tests the gate refusal.
    assign aux_demag_o = ringing_i && (stroke_cnt_r == 8'h00);
endmodule // mss_mains_model
`default_nettype wire

//--- test/tb_mains_sense_supply_supervisor.sv
// Self-checking testbench of the mains sense supply supervisor.
`timescale 1ns/10ps
`default_nettype none
module tb_mains_sense_supply_supervisor;
    localparam int unsigned WIN = 8;
    localparam int unsigned PRE = 40;
    localparam int unsigned NORM = 60;
    localparam int unsigned BURST = 100;
    localparam int unsigned GWAIT = 50;
    localparam int unsigned BO = 30;
    localparam int LIMIT = 20000;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_lvl = 1'b0, rs_lvl = 1'b0, rs_hyst = 1'b0, prot = 1'b0;
    logic c_low = 1'b0, c_high = 1'b0, burst = 1'b0, g_req = 1'b0, ringing = 1'b0;
    logic [9:0] mains_ua = 10'd300;
    logic s_bi, s_bo, demag_in;
    logic gnd, cap, hv_reg, bi, bo, sw_en, stroke, demag, gate, clamp, meas;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int a, b, c, d, len;

    mss_supervisor #(.WIN_CYC(WIN), .PRE_BI_CYC(PRE), .NORM_INT_CYC(NORM),
        .BURST_INT_CYC(BURST), .GROUP_WAIT_CYC(GWAIT), .BROWNOUT_CYC(BO)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_level_i(start_lvl),
        .restart_level_i(rs_lvl), .restart_hyst_i(rs_hyst), .sense_above_bi_i(s_bi),
        .sense_above_bo_i(s_bo), .protect_ok_i(prot), .ctrl_low_i(c_low),
        .ctrl_high_i(c_high), .aux_demag_i(demag_in), .burst_mode_i(burst),
        .gate_request_i(g_req), .sense_ground_o(gnd), .sense_capture_o(cap),
        .hv_regulate_o(hv_reg), .brownin_o(bi), .brownout_o(bo), .switch_enable_o(sw_en),
        .stroke_min_o(stroke), .demag_o(demag), .gate_on_o(gate), .aux_clamp_o(clamp),
        .aux_measure_o(meas));
    mss_mains_model #(.DEMAG_CYC(6)) partner (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mains_ua_i(mains_ua), .ringing_i(ringing),
        .gate_on_i(gate), .sense_above_bi_o(s_bi), .sense_above_bo_o(s_bo),
        .aux_demag_o(demag_in));

    // Clock at 25 MHz.
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // Cycle counter; a hang is cut short and counted as a mismatch.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Waits for the next window to open and returns its start cycle and length.
    task automatic win(output int start, output int wl);
        int n;
        n = 0;
        while (gnd === 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        while (gnd !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        start = cycles;
        wl = 0;
        while (gnd === 1'b1 && wl < 400) begin
            cyc(1);
            wl++;
        end
    endtask

    task automatic t_reset();
        chk("brownin in reset", bi, 1'b0);
        chk("enable in reset", sw_en, 1'b0);
        cyc(2);
        rst_i = 1'b0;
        cyc(3);
        chk("window without start level", gnd, 1'b0);
    endtask
    task automatic t_prebi();
        start_lvl = 1'b1;
        win(a, len);
        chk("window length", len, WIN);
        chk("capture after window", cap, 1'b1);
        cyc(1);
        chk("capture one cycle", cap, 1'b0);
        chk("hv regulate", hv_reg, 1'b1);
        win(b, len);
        win(c, len);
        win(d, len);
        chk("pre-brownin interval", b - a, PRE);
        chk("second interval", c - b, PRE);
        chk("group wait", d - c, WIN + GWAIT);
        chk("no brownin", bi, 1'b0);
    endtask
    task automatic t_brownin();
        mains_ua = 10'd700;
        win(a, len);
        cyc(5);
        chk("brownin", bi, 1'b1);
        chk("hv regulate off after brownin", hv_reg, 1'b0);
        chk("enable without protect", sw_en, 1'b0);
        prot = 1'b1;
        cyc(5);
        chk("enable with protect", sw_en, 1'b1);
        win(a, len);
        win(b, len);
        chk("normal interval", b - a, NORM);
        burst = 1'b1;
        win(a, len);
        win(b, len);
        chk("burst interval", b - a, BURST);
        burst = 1'b0;
    endtask
    task automatic t_strokes();
        c_high = 1'b1;
        rs_lvl = 1'b1;
        cyc(5);
        chk("stroke at restart", stroke, 1'b1);
        rs_lvl = 1'b0;
        rs_hyst = 1'b1;
        cyc(5);
        chk("stroke stop", stroke, 1'b0);
        rs_hyst = 1'b0;
        rs_lvl = 1'b1;
        cyc(5);
        chk("stroke repeat", stroke, 1'b1);
        c_high = 1'b0;
        c_low = 1'b1;
        cyc(5);
        chk("leave stroke mode", stroke, 1'b0);
        rs_lvl = 1'b0;
        c_low = 1'b0;
    endtask
    task automatic t_gate();
        int seen;
        seen = 0;
        g_req = 1'b1;
        repeat (10) begin
            cyc(1);
            seen += (gate === 1'b1);
        end
        chk("gate refused", seen, 0);
        chk("no demag", demag, 1'b0);
        g_req = 1'b0;
        ringing = 1'b1;
        cyc(5);
        chk("demag flag", demag, 1'b1);
        g_req = 1'b1;
        while (gate !== 1'b1 && seen < 4) begin
            cyc(1);
            seen++;
        end
        g_req = 1'b0;
        chk("gate on", gate, 1'b1);
        chk("aux clamp", clamp, 1'b1);
        chk("aux measure", meas, 1'b1);
        cyc(1);
        chk("demag cleared", demag, 1'b0);
        chk("gate one cycle", gate, 1'b0);
        // The synchronised aux level still lags the switch-off here.
        cyc(2);
        chk("no stale demag", demag, 1'b0);
        cyc(10);
        chk("demag after stroke", demag, 1'b1);
    endtask
    task automatic t_brownout();
        mains_ua = 10'd550;
        cyc(10);
        mains_ua = 10'd700;
        cyc(3);
        chk("short dip", bo, 1'b0);
        chk("still enabled", sw_en, 1'b1);
        mains_ua = 10'd550;
        cyc(BO);
        chk("no early brownout", bo, 1'b0);
        cyc(10);
        chk("brownout", bo, 1'b1);
        chk("switching stopped", sw_en, 1'b0);
    endtask
    task automatic t_rereset();
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(1);
        chk("brownin cleared", bi, 1'b0);
        chk("enable cleared", sw_en, 1'b0);
        win(a, len);
        win(b, len);
        chk("interval after reset", b - a, PRE);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        @(negedge ref_clk_i);
        t_reset();
        t_prebi();
        t_brownin();
        t_strokes();
        t_gate();
        t_brownout();
        t_rereset();
        conclude();
    end
endmodule // tb_mains_sense_supply_supervisor
`default_nettype wire
